/* idw_map.vh */
// Constants for the identify words 69..87 block: word values, masks,
// register offsets and reset values. Definitions only.
`ifndef IDW_MAP_VH
`define IDW_MAP_VH

// ----------------------------------------------------------------------
// Identify word indices
// ----------------------------------------------------------------------
`define IDW_FIRST 8'd69
`define IDW_LAST 8'd87

// ----------------------------------------------------------------------
// Fixed word values
// ----------------------------------------------------------------------
`define IDW_W69 16'h4230
`define IDW_W75 16'h001f
`define IDW_W76 16'h950e
`define IDW_W77 16'h0040
`define IDW_W78 16'h0044
`define IDW_W80 16'h03f8
`define IDW_W81 16'h0028
`define IDW_W82 16'h746b
`define IDW_W83 16'h7d09
`define IDW_W84 16'h6163
`define IDW_W85 16'h7008
`define IDW_W86 16'hbc01
`define IDW_W87 16'h6162

// ----------------------------------------------------------------------
// Variable bit masks and defaults
// ----------------------------------------------------------------------
`define IDW_M79 16'h007e
`define IDW_D79 16'h0040
`define IDW_M85 16'h05e1
`define IDW_D85 16'h0461
`define IDW_M86 16'h0238
`define IDW_D86 16'h0008
`define IDW_M87 16'h181c
`define IDW_D87 16'h0000
`define IDW_SEC_BIT 1
`define IDW_SPD_DEF 3'h3

// ----------------------------------------------------------------------
// Register word offsets (address bits 7:2)
// ----------------------------------------------------------------------
`define IDW_A_EN79 6'h00
`define IDW_A_EN85 6'h01
`define IDW_A_EN86 6'h02
`define IDW_A_EN87 6'h03
`define IDW_A_LINK 6'h04
`define IDW_A_SEL 6'h05
`define IDW_A_DATA 6'h06
`define IDW_LOCK_BIT 4

`endif

/* idw_words.v */
// Identify data words 69..87: fixed capability bits plus live enable,
// link speed and locking state, readable by index and over Wishbone.
// Assumes the identify read logic and command firmware share clk_i.
//
// Operation
// - Word 69 bits 5 and 4 fixed at one.
// - Word 69 bit 9 one; bits 13..10, 8..6, 3..0 zero.
// - Words 70 to 74 read all zeros.
// - Word 75 bits 4..0 all ones, upper bits zero.
// - Word 76 sets bits 15, 12, 10, 8; clears 14, 13, 11, 9, 7..4, 0.
// - Word 76 bits 3, 2, 1 one for three link speeds.
// - Word 77 bits 3..1 live link speed code, default 011; bit 0 zero.
// - Word 77 bit 6 one; bits 5, 4, 15..7 zero.
// - Word 78 sets bits 6 and 2 only.
// - Word 79 bit 6 defaults one, bits 5..1 default zero, all live.
// - Word 80 sets bits 9..3, others zero.
// - Word 82 bit 1 one, zero while locking mode enabled.
// - Word 82 sets 14,13,12,10,6,5,3,0; clears 15,11,9,8,7,2.
// - Bit 4 of words 82 and 85 always zero.
// - Word 83 sets bits 13,12,11,10,8,3,0; other low bits zero.
// - Word 84 sets bits 14, 13, 8, 6, 5, 1, 0; the rest zero.
// - Word 85 live bits 10,6,5,0 default one; 8,7 default zero.
// - Word 85 bit 1 zero, one while locking mode enabled.
// - Word 86 bits 15,13..10,0 one; bits 9, 5 live, default zero.
// - Word 86 bit 3 live power management enable, default one.
// - Word 87 sets 13,8,6,5,1; bits 4,3,2 live, default zero.
`include "idw_map.vh"
`default_nettype none

module idw_words (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Link negotiation result
    input wire link_upd_i,
    input wire [2:0] link_spd_i,
    // Identify read side
    input wire [7:0] id_index_i,
    output reg [15:0] id_data_o,
    output reg id_hit_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg ack_r;
    reg [15:0] en79_r;
    reg [15:0] en85_r;
    reg [15:0] en86_r;
    reg [15:0] en87_r;
    reg [2:0] spd_r;
    reg lock_r;
    reg [7:0] sel_r;
    wire req;
    wire wr;
    wire [5:0] radr;
    reg [31:0] rd_nxt;

    // ------------------------------------------------------------------
    // Word composition
    // ------------------------------------------------------------------
    function [15:0] word_of;
        input [7:0] idx;
        begin
            case (idx)
                8'd69: word_of = `IDW_W69;
                8'd75: word_of = `IDW_W75;
                8'd76: word_of = `IDW_W76;
                8'd77: word_of = `IDW_W77 | {12'h000, spd_r, 1'b0};
                8'd78: word_of = `IDW_W78;
                8'd79: word_of = en79_r & `IDW_M79;
                8'd80: word_of = `IDW_W80;
                8'd81: word_of = `IDW_W81;
                // Security supported drops while locking owns the drive
                8'd82: word_of = `IDW_W82 & ~{14'h0000, lock_r, 1'b0};
                8'd83: word_of = `IDW_W83;
                8'd84: word_of = `IDW_W84;
                8'd85: word_of = `IDW_W85 | (en85_r & `IDW_M85)
                                 | {14'h0000, lock_r, 1'b0};
                8'd86: word_of = `IDW_W86 | (en86_r & `IDW_M86);
                8'd87: word_of = `IDW_W87 | (en87_r & `IDW_M87);
                default: word_of = 16'h0000;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Identify output, one cycle after the index
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            id_data_o <= 16'h0000;
            id_hit_o <= 1'b0;
        end else begin
            id_data_o <= word_of(id_index_i);
            id_hit_o <= (id_index_i >= `IDW_FIRST) && (id_index_i <= `IDW_LAST);
        end
    end

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    // Ack follows one cycle after the strobe; writes land on the ack edge
    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & ack_r;
    assign wb_ack_o = ack_r;
    assign radr = wb_adr_i[7:2];

    function [15:0] lanes;
        input [15:0] old;
        input [15:0] msk;
        begin
            lanes = old;
            if (wb_sel_i[0]) begin
                lanes[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                lanes[15:8] = wb_dat_i[15:8];
            end
            lanes = lanes & msk;
        end
    endfunction

    always @* begin
        case (radr)
            `IDW_A_EN79: rd_nxt = {16'h0000, en79_r};
            `IDW_A_EN85: rd_nxt = {16'h0000, en85_r};
            `IDW_A_EN86: rd_nxt = {16'h0000, en86_r};
            `IDW_A_EN87: rd_nxt = {16'h0000, en87_r};
            `IDW_A_LINK: rd_nxt = {27'h0000000, lock_r, 1'b0, spd_r};
            `IDW_A_SEL: rd_nxt = {24'h000000, sel_r};
            `IDW_A_DATA: rd_nxt = {16'h0000, word_of(sel_r)};
            default: rd_nxt = 32'h00000000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            ack_r <= req & ~ack_r;
            if (req & ~ack_r) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // Live feature state
    // ------------------------------------------------------------------
    // A link result in the same cycle as a software write wins: it is
    // the fresher fact about the wire.
    always @(posedge clk_i) begin
        if (rst_i) begin
            en79_r <= `IDW_D79;
            en85_r <= `IDW_D85;
            en86_r <= `IDW_D86;
            en87_r <= `IDW_D87;
            spd_r <= `IDW_SPD_DEF;
            lock_r <= 1'b0;
            sel_r <= `IDW_FIRST;
        end else begin
            if (wr && radr == `IDW_A_EN79) begin
                en79_r <= lanes(en79_r, `IDW_M79);
            end
            if (wr && radr == `IDW_A_EN85) begin
                en85_r <= lanes(en85_r, `IDW_M85);
            end
            if (wr && radr == `IDW_A_EN86) begin
                en86_r <= lanes(en86_r, `IDW_M86);
            end
            if (wr && radr == `IDW_A_EN87) begin
                en87_r <= lanes(en87_r, `IDW_M87);
            end
            if (wr && radr == `IDW_A_SEL && wb_sel_i[0]) begin
                sel_r <= wb_dat_i[7:0];
            end
            if (wr && radr == `IDW_A_LINK && wb_sel_i[0]) begin
                lock_r <= wb_dat_i[`IDW_LOCK_BIT];
            end
            if (link_upd_i) begin
                spd_r <= link_spd_i;
            end else if (wr && radr == `IDW_A_LINK && wb_sel_i[0]) begin
                spd_r <= wb_dat_i[2:0];
            end
        end
    end

endmodule // idw_words
`default_nettype wire

/* idw_words_properties.sv */
// Checker for idw_words: values seen at the identify port.
// Assumes one clock and a synchronous active-high reset.
`include "idw_map.vh"
`default_nettype none
module idw_words_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Identify port
    input wire logic [7:0] id_index_i,
    input wire logic [15:0] id_data_o,
    input wire logic id_hit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    w69_value_a: assert property (id_index_i == 8'h45 |=> id_data_o == `IDW_W69)
        else $error("bad word 69");
    rsvd_zero_a: assert property (id_index_i inside {[8'h46:8'h4a]} |=> id_data_o == 0)
        else $error("reserved word not zero");
    w76_value_a: assert property (id_index_i == 8'h4c |=> id_data_o == `IDW_W76)
        else $error("bad word 76");
    speed_fix_a: assert property (id_index_i == 8'h4d |=>
        (id_data_o & 16'hfff1) == 16'h0040)
        else $error("bad word 77 fixed bits");
    pkt_zero_a: assert property (id_index_i inside {8'h52, 8'h55} |=> !id_data_o[4])
        else $error("packet bit set");
    sig_bits_a: assert property (id_index_i inside {8'h53, 8'h54, 8'h57} |=>
        id_data_o[15:14] == 2'h1)
        else $error("bad signature");
    miss_zero_a: assert property (!(id_index_i inside {[8'h45:8'h57]}) |=>
        id_data_o == 0 && !id_hit_o)
        else $error("out of range word");
    hit_flag_a: assert property (id_index_i inside {[8'h45:8'h57]} |=> id_hit_o)
        else $error("hit missing");
    cover property (id_index_i == 8'h4d ##1 id_hit_o);
    cover property (id_index_i == 8'h55 ##1 id_data_o[1]);
    cover property (id_index_i == 8'h52 ##1 !id_data_o[1]);
endmodule // idw_words_chk
bind idw_words idw_words_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .id_index_i(id_index_i),
    .id_data_o(id_data_o), .id_hit_o(id_hit_o));
`default_nettype wire

/* idw_link_peer.sv */
// Link negotiation peer: reports a new speed code with a one-cycle pulse.
// Assumes the bench raises go_i for one cycle per negotiation.
`default_nettype none
module idw_link_peer (
    // Clock and request
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [2:0] spd_i,
    // Link result
    output var logic upd_o,
    output var logic [2:0] spd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        upd_o = 1'b0;
        spd_o = 3'h0;
    end
    // Speed only counts with the pulse, so keep it moving in between
    always @(posedge clk_i) begin
        upd_o <= go_i;
        spd_o <= go_i ? spd_i : ~spd_o;
    end
endmodule // idw_link_peer
`default_nettype wire

/* idw_words_tb.sv */
// Bench for idw_words: sweeps identify words, changes live bits.
// Assumes a 40 MHz clock and the link peer at the speed inputs.
`include "idw_map.vh"
`default_nettype none
module idw_words_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, req = 0, we = 0, ack, hit, upd, go = 0, lock;
    logic [7:0] adr = 0, idx = 0;
    logic [31:0] dat = 0, rdat, q, rs = 20358;
    logic [15:0] idat, d, e [4];
    logic [15:0] msk [4] = '{`IDW_M79, `IDW_M85, `IDW_M86, `IDW_M87};
    logic [2:0] spd, pspd = 0, lspd;
    int n_fail = 0, n_checks = 0;
    idw_words dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .link_upd_i(upd), .link_spd_i(lspd), .id_index_i(idx),
        .id_data_o(idat), .id_hit_o(hit));
    idw_link_peer peer_u (.clk_i(clk_i), .go_i(go), .spd_i(pspd), .upd_o(upd), .spd_o(lspd));
    initial forever #12.5 clk_i = ~clk_i;
    function automatic logic [15:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[15:0];
    endfunction
    function automatic logic [15:0] exp_w(input logic [7:0] i);
        case (i)
            8'h45: return `IDW_W69;
            8'h4b: return `IDW_W75;
            8'h4c: return `IDW_W76;
            8'h4d: return `IDW_W77 | {12'h0, spd, 1'b0};
            8'h4e: return `IDW_W78;
            8'h4f: return e[0];
            8'h50: return `IDW_W80;
            8'h51: return `IDW_W81;
            8'h52: return (`IDW_W82 & 16'hfffd) | {14'h0, ~lock, 1'b0};
            8'h53: return `IDW_W83;
            8'h54: return `IDW_W84;
            8'h55: return `IDW_W85 | e[1] | {14'h0, lock, 1'b0};
            8'h56: return `IDW_W86 | e[2];
            8'h57: return `IDW_W87 | e[3];
            default: return 16'h0;
        endcase
    endfunction
    task automatic dflt();
        e = '{`IDW_D79, `IDW_D85, `IDW_D86, `IDW_D87};
        spd = `IDW_SPD_DEF;
        lock = 0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] v);
        int n = 0;
        @(posedge clk_i);
        req <= 1;
        we <= w;
        adr <= a;
        dat <= {16'h0, v};
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
        q = rdat;
        req <= 0;
        if (n >= 50) n_fail++;
    endtask
    task automatic sweep();
        for (int i = 8'h40; i < 8'h5c; i++) begin
            @(posedge clk_i);
            idx <= 8'(i);
            @(posedge clk_i);
            #1 chk({15'h0, hit, idat}, {15'h0, i >= 8'h45 && i <= 8'h57, exp_w(8'(i))});
        end
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk_i);
        n_fail++;
        end_of_test();
    end
    initial begin
        dflt();
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        sweep();
        for (int k = 0; k < 6; k++) begin
            d = rnd();
            wb(1, 8'(k % 4 * 4), d);
            e[k % 4] = d & msk[k % 4];
            wb(0, 8'(k % 4 * 4), 0);
            chk(q, {16'h0, e[k % 4]});
            d = rnd();
            wb(1, 8'h10, d);
            lock = d[4];
            @(posedge clk_i) go <= 1;
            pspd <= d[10:8];
            @(posedge clk_i) go <= 0;
            spd = d[10:8];
            wb(0, 8'h10, 0);
            chk(q, {27'h0, lock, 1'b0, spd});
            sweep();
        end
        wb(1, 8'h14, 16'h4d);
        wb(1, 8'h18, 16'hffff);
        wb(0, 8'h18, 0);
        chk(q, {16'h0, exp_w(8'h4d)});
        wb(1, 8'h40, 16'hffff);
        wb(0, 8'h40, 0);
        chk(q, 32'h0);
        @(posedge clk_i) rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        dflt();
        sweep();
        end_of_test();
    end
endmodule // idw_words_tb
`default_nettype wire
